// ==== rtl/rsc_reset_ctrl.sv ====
// Decided for this implementation: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
module rsc_reset_ctrl
   import rsc_pkg::*;
(
   // clock and reset
   input  wire logic                       aclk,
   input  wire logic                       aresetn,
   // board reset pins
   input  wire logic                       power_on_reset_n,
   input  wire logic                       hard_reset_pin_n_i,
   output logic                            hard_reset_pin_n_o,
   output logic                            hard_reset_pin_n_oe,
   // strap inputs
   input  wire logic [1:0]                 boot_mode_straps,
   input  wire logic                       watchdog_enable_strap,
   input  wire logic                       host_byte_width_strap,
   input  wire logic                       host_mode_strap,
   // internal reset requests
   input  wire logic                       watchdog_expired,
   input  wire logic                       bus_monitor_expired,
   input  wire logic                       tap_boundary_cmd,
   // reset outputs to the device, active low except soft_reset_internal, which is active high
   output logic                            clock_gen_reset_n,
   output logic                            core_reset_n,
   output logic                            periph_reset_n,
   output logic                            monitor_reset_n,
   output logic                            clock_stop_reset_n,
   output logic                            soft_reset_internal,
   // latched straps
   output logic [1:0]                      boot_mode_q,
   output logic                            watchdog_enable_q,
   output logic                            host_byte_width_q,
   output logic                            host_mode_q,
   // interrupt
   output logic                            irq,
   // AXI4-Lite write address
   input  wire logic [7:0]                 s_axi_awaddr,
   input  wire logic                       s_axi_awvalid,
   output logic                            s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0]                s_axi_wdata,
   input  wire logic [3:0]                 s_axi_wstrb,
   input  wire logic                       s_axi_wvalid,
   output logic                            s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]                      s_axi_bresp,
   output logic                            s_axi_bvalid,
   input  wire logic                       s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [7:0]                 s_axi_araddr,
   input  wire logic                       s_axi_arvalid,
   output logic                            s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]                     s_axi_rdata,
   output logic [1:0]                      s_axi_rresp,
   output logic                            s_axi_rvalid,
   input  wire logic                       s_axi_rready
);

   rsc_state_t           state_q;
   logic [CNT_W-1:0]     cnt_q;
   logic                 por_sync_n;
   logic                 hard_sync_n;
   logic                 por_sync_d1_q;
   logic                 hard_req;
   logic                 soft_req;
   logic                 soft_q;
   logic [EV_W-1:0]      events;
   logic [EV_W-1:0]      status_q;
   logic [EV_W-1:0]      mask_q;
   logic [EV_W-1:0]      cause_q;
   logic [EV_W-1:0]      pending_q;
   logic [1:0]           ctrl_q;
   logic                 aw_done_q;
   logic                 w_done_q;
   logic [7:0]           awaddr_q;
   logic [31:0]          wdata_q;
   logic [3:0]           wstrb_q;
   logic                 wr_fire;
   logic                 rd_fire;
   logic                 status_rd;
   logic [1:0]           drive_hist_q;
   logic                 ext_hard;

   // both board inputs are asynchronous to the reference clock
   rsc_sync u_sync_por
   (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .async_in (power_on_reset_n),
      .sync_out (por_sync_n)
   );

   rsc_sync u_sync_hard
   (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .async_in (hard_reset_pin_n_i),
      .sync_out (hard_sync_n)
   );

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         por_sync_d1_q <= 1'b0;
      else
         por_sync_d1_q <= por_sync_n;
   end

   // the synchroniser still shows our own pull for two edges after release
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         drive_hist_q <= 2'b11;
      else
         drive_hist_q <= {drive_hist_q[0], state_q != RSC_ST_RUN};
   end

   // an external pin low is ignored while we drive it ourselves
   assign ext_hard = !hard_sync_n && state_q == RSC_ST_RUN && drive_hist_q == 2'b00;
   assign hard_req = ext_hard
                   || (watchdog_expired && ctrl_q[CTL_WDOG_EN])
                   || (bus_monitor_expired && ctrl_q[CTL_BMON_EN]);
   assign soft_req = tap_boundary_cmd;

   always_comb
   begin
      events              = '0;
      events[EV_POR]      = !por_sync_n;
      events[EV_HARD_EXT] = ext_hard;
      events[EV_WATCHDOG] = watchdog_expired && ctrl_q[CTL_WDOG_EN];
      events[EV_BUS_MON]  = bus_monitor_expired && ctrl_q[CTL_BMON_EN];
      events[EV_SOFT]     = tap_boundary_cmd;
   end

   // sequencer: power-on holds until release plus 521 cycles
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_q <= RSC_ST_POR;
         cnt_q   <= CNT_ZERO;
      end
      else if (!por_sync_n)
      begin
         state_q <= RSC_ST_POR;
         cnt_q   <= CNT_ZERO;
      end
      else
      begin
         case (state_q)
            RSC_ST_POR:
            begin
               if (cnt_q == POR_HOLD_LAST)
               begin
                  state_q <= RSC_ST_RUN;
                  cnt_q   <= CNT_ZERO;
               end
               else
                  cnt_q <= cnt_q + 10'h001;
            end
            RSC_ST_HARD:
            begin
               if (cnt_q == HARD_HOLD_LAST)
               begin
                  state_q <= RSC_ST_RUN;
                  cnt_q   <= CNT_ZERO;
               end
               else
                  cnt_q <= cnt_q + 10'h001;
            end
            RSC_ST_RUN:
            begin
               if (hard_req)
               begin
                  state_q <= RSC_ST_HARD;
                  cnt_q   <= CNT_ZERO;
               end
            end
            default:
            begin
               state_q <= RSC_ST_POR;
               cnt_q   <= CNT_ZERO;
            end
         endcase
      end
   end

   // soft reset lasts while the boundary-scan command is active
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         soft_q <= 1'b0;
      else
         soft_q <= soft_req && state_q == RSC_ST_RUN;
   end

   // open drain: only ever pulls low
   assign hard_reset_pin_n_o  = 1'b0;
   assign hard_reset_pin_n_oe = (state_q != RSC_ST_RUN);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         clock_gen_reset_n   <= 1'b0;
         core_reset_n        <= 1'b0;
         periph_reset_n      <= 1'b0;
         monitor_reset_n     <= 1'b0;
         clock_stop_reset_n  <= 1'b0;
         soft_reset_internal <= 1'b0;
      end
      else
      begin
         clock_gen_reset_n   <= !(state_q == RSC_ST_POR);
         core_reset_n        <= state_q == RSC_ST_RUN && !soft_q;
         periph_reset_n      <= state_q == RSC_ST_RUN && !soft_q;
         monitor_reset_n     <= state_q == RSC_ST_RUN && !soft_q;
         clock_stop_reset_n  <= state_q == RSC_ST_RUN && !soft_q;
         soft_reset_internal <= soft_q;
      end
   end

   // straps caught on the release edge of the synchronised power-on input
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         boot_mode_q       <= 2'h0;
         watchdog_enable_q <= 1'b0;
         host_byte_width_q <= 1'b0;
         host_mode_q       <= 1'b0;
      end
      else if (por_sync_n && !por_sync_d1_q)
      begin
         boot_mode_q       <= boot_mode_straps;
         watchdog_enable_q <= watchdog_enable_strap;
         host_byte_width_q <= host_byte_width_strap;
         host_mode_q       <= host_mode_strap;
      end
   end

   // cause: sources of the reset now running, frozen once the device runs
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pending_q <= '0;
         cause_q   <= '0;
      end
      else
      begin
         if (state_q == RSC_ST_RUN && !soft_q && (hard_req || soft_req))
            pending_q <= events;
         else if (state_q == RSC_ST_RUN && !soft_q)
            pending_q <= '0;
         else
            pending_q <= pending_q | events;
         if (state_q != RSC_ST_RUN && !por_sync_n)
            cause_q <= '0;
         else if ((state_q != RSC_ST_RUN || soft_q) && |(pending_q | events))
            cause_q <= pending_q | events;
      end
   end

   // AXI4-Lite slave: one write and one read at a time
   assign s_axi_awready = !aw_done_q && !s_axi_bvalid;
   assign s_axi_wready  = !w_done_q && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign wr_fire   = aw_done_q && w_done_q;
   assign rd_fire   = s_axi_arvalid && s_axi_arready;
   assign status_rd = rd_fire && s_axi_araddr == ADDR_STATUS;
   assign irq       = |(status_q & mask_q);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_done_q    <= 1'b0;
         w_done_q     <= 1'b0;
         awaddr_q     <= 8'h00;
         wdata_q      <= 32'h0000_0000;
         wstrb_q      <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_done_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_done_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
         end
         if (wr_fire)
         begin
            aw_done_q    <= 1'b0;
            w_done_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awaddr_q == ADDR_MASK || awaddr_q == ADDR_CONTROL
                             || awaddr_q == ADDR_STATUS || awaddr_q == ADDR_CAUSE
                             || awaddr_q == ADDR_STRAPS) ? RESP_OKAY : RESP_SLVERR;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // mask and control registers; low byte lane carries every field
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         mask_q <= '0;
         ctrl_q <= CTL_RESET;
      end
      else if (wr_fire && wstrb_q[0])
      begin
         if (awaddr_q == ADDR_MASK)
            mask_q <= wdata_q[EV_W-1:0];
         else if (awaddr_q == ADDR_CONTROL)
            ctrl_q <= wdata_q[1:0];
      end
   end

   // sticky status, cleared by reading it; a new event wins over the clear
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         status_q <= '0;
      else
         status_q <= (status_rd ? '0 : status_q) | events;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= RESP_OKAY;
      end
      else if (rd_fire)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= RESP_OKAY;
         if (s_axi_araddr == ADDR_STATUS)
            s_axi_rdata <= {27'h0, status_q};
         else if (s_axi_araddr == ADDR_MASK)
            s_axi_rdata <= {27'h0, mask_q};
         else if (s_axi_araddr == ADDR_CAUSE)
            s_axi_rdata <= {27'h0, cause_q};
         else if (s_axi_araddr == ADDR_STRAPS)
            s_axi_rdata <= {27'h0, host_mode_q, host_byte_width_q,
                            watchdog_enable_q, boot_mode_q};
         else if (s_axi_araddr == ADDR_CONTROL)
            s_axi_rdata <= {30'h0, ctrl_q};
         else
         begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_SLVERR;
         end
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

endmodule

// ==== rtl/rsc_pkg.sv ====
package rsc_pkg;

   // reference clock: 200 MHz
   localparam int unsigned CLK_PERIOD_PS        = 5000;

   // power-on release to hard-reset-pin release, in reference clock cycles
   localparam int unsigned POR_HOLD_CYCLES      = 521;
   // least power-on hold the board must supply, in reference clock cycles
   localparam int unsigned POR_MIN_CYCLES       = 16;
   // least hard reset pulse that the device itself drives, in cycles
   localparam int unsigned HARD_HOLD_CYCLES     = 16;
   localparam int unsigned CNT_W                = 10;
   localparam logic [9:0]  POR_HOLD_LAST        = 10'(POR_HOLD_CYCLES - 1);
   localparam logic [9:0]  HARD_HOLD_LAST       = 10'(HARD_HOLD_CYCLES - 1);
   localparam logic [9:0]  CNT_ZERO             = 10'h000;

   // AXI4-Lite register map (byte addresses)
   localparam logic [7:0]  ADDR_STATUS          = 8'h00;
   localparam logic [7:0]  ADDR_MASK            = 8'h04;
   localparam logic [7:0]  ADDR_CAUSE           = 8'h08;
   localparam logic [7:0]  ADDR_STRAPS          = 8'h0C;
   localparam logic [7:0]  ADDR_CONTROL         = 8'h10;

   // cause / event bit positions, shared by status, mask and cause
   localparam int unsigned EV_W                 = 5;
   localparam int unsigned EV_POR               = 0;
   localparam int unsigned EV_HARD_EXT          = 1;
   localparam int unsigned EV_WATCHDOG          = 2;
   localparam int unsigned EV_BUS_MON           = 3;
   localparam int unsigned EV_SOFT              = 4;

   // control register fields
   localparam int unsigned CTL_WDOG_EN          = 0;
   localparam int unsigned CTL_BMON_EN          = 1;
   localparam logic [1:0]  CTL_RESET            = 2'h0;

   localparam int unsigned STRAP_W              = 5;
   localparam logic [1:0]  RESP_OKAY            = 2'h0;
   localparam logic [1:0]  RESP_SLVERR          = 2'h2;

   typedef enum logic [1:0]
   {
      RSC_ST_POR  = 2'b00,
      RSC_ST_HARD = 2'b01,
      RSC_ST_RUN  = 2'b10
   } rsc_state_t;

endpackage

// ==== rtl/rsc_sync.sv ====
`timescale 1ns/1ps
// two-flop level synchroniser; the first flop feeds only the second
module rsc_sync
(
   // clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // level in and out
   input  wire logic async_in,
   output logic      sync_out
);
   logic meta_q;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         meta_q   <= 1'b0;
         sync_out <= 1'b0;
      end
      else
      begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule

// ==== tb/rsc_chk.sv ====
`timescale 1ns/1ps
module rsc_chk
(
   // clock and reset
   input wire logic       aclk,
   input wire logic       aresetn,
   // pins and requests
   input wire logic       power_on_reset_n,
   input wire logic       tap_boundary_cmd,
   input wire logic       hard_reset_pin_n_o,
   input wire logic       hard_reset_pin_n_oe,
   // reset outputs
   input wire logic       clock_gen_reset_n,
   input wire logic       core_reset_n,
   input wire logic       periph_reset_n,
   input wire logic       monitor_reset_n,
   input wire logic       clock_stop_reset_n,
   input wire logic       soft_reset_internal,
   // latched straps
   input wire logic [1:0] boot_mode_q,
   input wire logic       watchdog_enable_q,
   input wire logic       host_byte_width_q,
   input wire logic       host_mode_q
);
   logic [9:0] up_q;
   logic       all_low;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // cycles since the board let go of power-on; saturates so later hard resets are recognised
   always_ff @(posedge aclk)
   begin
      if (!aresetn || !power_on_reset_n)
         up_q <= 10'h000;
      else if (up_q != 10'h3FF)
         up_q <= up_q + 10'h001;
   end
   assign all_low = !core_reset_n && !periph_reset_n && !monitor_reset_n && !clock_stop_reset_n;
   chk_pin_open_drain: assert property (
      hard_reset_pin_n_oe |-> !hard_reset_pin_n_o) else $error("pin driven high");
   chk_por_hold_min: assert property (
      up_q < 10'h209 && !clock_gen_reset_n |-> hard_reset_pin_n_oe)
      else $error("hard pin released early");
   chk_por_hold_max: assert property (
      up_q == 10'h20E |-> !hard_reset_pin_n_oe) else $error("hard pin held too long");
   chk_straps_por_only: assert property (
      !$stable({boot_mode_q, watchdog_enable_q, host_byte_width_q, host_mode_q})
      |-> !clock_gen_reset_n) else $error("straps changed outside power-on");
   chk_soft_no_pin: assert property (
      soft_reset_internal |-> clock_gen_reset_n && !hard_reset_pin_n_oe)
      else $error("soft reset touched pin or clock generator");
   chk_hard_len: assert property (
      $rose(hard_reset_pin_n_oe) && up_q == 10'h3FF
      |-> ##15 hard_reset_pin_n_oe ##1 !hard_reset_pin_n_oe) else $error("hard length");
   chk_hard_outs: assert property (
      $rose(hard_reset_pin_n_oe) && up_q == 10'h3FF |=> all_low && clock_gen_reset_n)
      else $error("hard reset outputs wrong");
   chk_soft_outs: assert property (
      $rose(soft_reset_internal) |-> ##1 all_low) else $error("soft reset outputs wrong");
   chk_tap_soft: assert property (
      $rose(tap_boundary_cmd) && up_q == 10'h3FF && !hard_reset_pin_n_oe
      |-> ##[1:3] soft_reset_internal) else $error("soft reset missing");
   cov_soft: cover property ($rose(soft_reset_internal));
   cov_por: cover property ($fell(clock_gen_reset_n));
   cov_hard: cover property ($rose(hard_reset_pin_n_oe) && up_q == 10'h3FF);
endmodule

bind rsc_reset_ctrl rsc_chk u_chk (.*);

// ==== tb/rsc_board.sv ====
`timescale 1ns/1ps
module rsc_board
(
   // clock
   input  wire logic aclk,
   // bench commands
   input  wire logic por_req,
   input  wire logic ext_pull,
   // device drive on the hard reset pin
   input  wire logic pin_oe,
   input  wire logic pin_o,
   // board levels
   output logic      power_on_reset_n,
   output logic      pin_n
);
   logic [4:0] low_cnt_q = 5'h00;
   // a request restarts the hold, so the supervisor never gives a short pulse
   always_ff @(posedge aclk)
   begin
      if (por_req)
         low_cnt_q <= 5'h00;
      else if (low_cnt_q != 5'h10)
         low_cnt_q <= low_cnt_q + 5'h01;
   end
   assign power_on_reset_n = !por_req && (low_cnt_q == 5'h10);
   // pulled up: a released line reads high, any low driver wins
   assign pin_n = !((pin_oe && !pin_o) || ext_pull);
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/1ps
module tb;
   import rsc_pkg::*;
   typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d; logic [1:0] r;} rsc_row_t;
   logic        aclk = 1'b0, aresetn = 1'b0, por_req = 1'b1, ext_pull = 1'b0;
   logic        power_on_reset_n, hard_reset_pin_n_i, hard_reset_pin_n_o, hard_reset_pin_n_oe;
   logic [4:0]  straps = 5'h16;
   logic [1:0]  boot_mode_straps, boot_mode_q, s_axi_bresp, s_axi_rresp;
   logic        watchdog_enable_strap, host_byte_width_strap, host_mode_strap;
   logic        watchdog_expired = 1'b0, bus_monitor_expired = 1'b0, tap_boundary_cmd = 1'b0;
   logic        clock_gen_reset_n, core_reset_n, periph_reset_n, monitor_reset_n, irq;
   logic        clock_stop_reset_n, soft_reset_internal;
   logic        watchdog_enable_q, host_byte_width_q, host_mode_q;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   int          mismatches = 0, n_compared = 0;
   rsc_row_t    rows [8] = '{
      '{1'b1, ADDR_MASK, 32'h1F, RESP_OKAY}, '{1'b0, ADDR_MASK, 32'h1F, RESP_OKAY},
      '{1'b1, ADDR_CONTROL, 32'h3, RESP_OKAY}, '{1'b0, ADDR_CONTROL, 32'h3, RESP_OKAY},
      '{1'b1, ADDR_CAUSE, 32'h1F, RESP_OKAY}, '{1'b0, ADDR_CAUSE, 32'h1, RESP_OKAY},
      '{1'b0, 8'h14, 32'h0, RESP_SLVERR}, '{1'b1, 8'h14, 32'h1, RESP_SLVERR}};
   assign {host_mode_strap, host_byte_width_strap, watchdog_enable_strap, boot_mode_straps} = straps;
   always #2.5 aclk = ~aclk;
   rsc_reset_ctrl dut (.*);
   rsc_board board (.aclk(aclk), .por_req(por_req), .ext_pull(ext_pull),
      .pin_oe(hard_reset_pin_n_oe), .pin_o(hard_reset_pin_n_o),
      .power_on_reset_n(power_on_reset_n), .pin_n(hard_reset_pin_n_i));
   task automatic report_and_stop();
      if (mismatches == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic timed_out(input int i);
      if (i >= 1000)
      begin
         mismatches++;
         report_and_stop();
      end
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      int i;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (i = 0; i < 1000 && s_axi_bvalid !== 1'b1; i++)
      begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready === 1'b1)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready === 1'b1)
            s_axi_wvalid <= 1'b0;
      end
      timed_out(i);
      s_axi_bready <= 1'b0;
      cmp(32'(s_axi_bresp), 32'(r));
   endtask
   task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      int i;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (i = 0; i < 1000 && s_axi_rvalid !== 1'b1; i++)
      begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready === 1'b1)
            s_axi_arvalid <= 1'b0;
      end
      timed_out(i);
      s_axi_rready <= 1'b0;
      cmp(s_axi_rdata, d);
      cmp(32'(s_axi_rresp), 32'(r));
   endtask
   task automatic wait_idle();
      int i;
      for (i = 0; i < 1000; i++)
      begin
         @(posedge aclk);
         if (hard_reset_pin_n_oe === 1'b0 && core_reset_n === 1'b1 &&
             clock_gen_reset_n === 1'b1 && soft_reset_internal === 1'b0)
            break;
      end
      timed_out(i);
   endtask
   task automatic chk_straps(input logic [4:0] s);
      cmp(32'({host_mode_q, host_byte_width_q, watchdog_enable_q, boot_mode_q}), 32'(s));
      axr(ADDR_STRAPS, 32'(s), RESP_OKAY);
   endtask
   initial
   begin
      tick(10);
      aresetn <= 1'b1;
      por_req <= 1'b0;
      tick(4);
      cmp(32'({hard_reset_pin_n_oe, clock_gen_reset_n, core_reset_n}), 32'h4);
      wait_idle();
      chk_straps(5'h16);
      axr(ADDR_STATUS, 32'h1, RESP_OKAY);
      axr(ADDR_STATUS, 32'h0, RESP_OKAY);
      foreach (rows[k])
         if (rows[k].wr)
            axw(rows[k].a, rows[k].d, rows[k].r);
         else
            axr(rows[k].a, rows[k].d, rows[k].r);
      cmp(32'(irq), 32'h0);
      // new strap levels must not be taken by a hard reset
      straps <= 5'h09;
      watchdog_expired <= 1'b1;
      tick(1);
      watchdog_expired <= 1'b0;
      tick(3);
      cmp(32'({hard_reset_pin_n_oe, core_reset_n, clock_gen_reset_n}), 32'h5);
      wait_idle();
      chk_straps(5'h16);
      axr(ADDR_CAUSE, 32'h1 << EV_WATCHDOG, RESP_OKAY);
      axw(ADDR_MASK, 32'h1F, RESP_OKAY);
      cmp(32'(irq), 32'h1);
      axr(ADDR_STATUS, 32'h1 << EV_WATCHDOG, RESP_OKAY);
      cmp(32'(irq), 32'h0);
      axw(ADDR_MASK, 32'h0, RESP_OKAY);
      axw(ADDR_CONTROL, 32'h2, RESP_OKAY);
      bus_monitor_expired <= 1'b1;
      tick(1);
      bus_monitor_expired <= 1'b0;
      tick(3);
      cmp(32'({hard_reset_pin_n_oe, core_reset_n}), 32'h2);
      wait_idle();
      axr(ADDR_CAUSE, 32'h1 << EV_BUS_MON, RESP_OKAY);
      cmp(32'(irq), 32'h0);
      axw(ADDR_MASK, 32'h1F, RESP_OKAY);
      cmp(32'(irq), 32'h1);
      axr(ADDR_STATUS, 32'h1 << EV_BUS_MON, RESP_OKAY);
      ext_pull <= 1'b1;
      tick(3);
      ext_pull <= 1'b0;
      tick(3);
      cmp(32'({hard_reset_pin_n_oe, core_reset_n, clock_gen_reset_n}), 32'h5);
      wait_idle();
      axr(ADDR_CAUSE, 32'h1 << EV_HARD_EXT, RESP_OKAY);
      tap_boundary_cmd <= 1'b1;
      tick(4);
      cmp(32'({soft_reset_internal, hard_reset_pin_n_oe, periph_reset_n}), 32'h4);
      tap_boundary_cmd <= 1'b0;
      wait_idle();
      axr(ADDR_CAUSE, 32'h1 << EV_SOFT, RESP_OKAY);
      chk_straps(5'h16);
      por_req <= 1'b1;
      tick(1);
      por_req <= 1'b0;
      tick(8);
      cmp(32'({clock_gen_reset_n, hard_reset_pin_n_oe}), 32'h1);
      wait_idle();
      chk_straps(5'h09);
      axr(ADDR_CAUSE, 32'h1 << EV_POR, RESP_OKAY);
      // watchdog reset enable is still clear from the last control write
      watchdog_expired <= 1'b1;
      tick(1);
      watchdog_expired <= 1'b0;
      tick(6);
      cmp(32'(hard_reset_pin_n_oe), 32'h0);
      report_and_stop();
   end
endmodule
